/* File: logic/dac_host_end.sv */
`timescale 1ns/1ps
module dac_host_end #(
  parameter int unsigned STARTUP_WAIT_CYC = dac_link_pkg::STARTUP_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  dac_link_if.host link,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import dac_link_pkg::*;

  typedef enum logic [5:0] {
    H_BOOT = 6'b000001,
    H_IDLE = 6'b000010,
    H_CMD = 6'b000100,
    H_GAP = 6'b001000,
    H_DATA = 6'b010000,
    H_END = 6'b100000
  } host_state_e;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_WDATA) || (a == ADDR_RDATA) || (a == ADDR_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [5:0] ctrl_reg;
  logic [23:0] tx_word_reg;
  logic [23:0] rx_word_reg;
  logic go_reg;
  host_state_e state_reg;

  wire logic do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  wire logic wr_full = (s_axi_wstrb_in == 4'hf);
  wire logic busy = (state_reg != H_IDLE);
  wire logic [31:0] status_word = {30'h00000000, state_reg != H_BOOT, busy && state_reg != H_BOOT};
  wire logic [31:0] rd_word = (s_axi_araddr_in == ADDR_CTRL) ? {26'h0000000, ctrl_reg} :
                              (s_axi_araddr_in == ADDR_WDATA) ? {8'h00, tx_word_reg} :
                              (s_axi_araddr_in == ADDR_RDATA) ? {8'h00, rx_word_reg} : status_word;

  // Address and data taken in either order; response after both
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg <= 1'b1;
        s_axi_awready_out <= 1'b0;
        awaddr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg <= 1'b1;
        s_axi_wready_out <= 1'b0;
        wdata_reg <= wr_full ? s_axi_wdata_in : 32'h00000000;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= addr_ok(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // Control registers; go is a one-cycle pulse, dropped when busy
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= 6'h00;
      tx_word_reg <= 24'h000000;
      go_reg <= 1'b0;
    end else begin
      go_reg <= do_write && awaddr_reg == ADDR_CTRL && wdata_reg[CTRL_GO] && !busy;
      if (do_write && awaddr_reg == ADDR_CTRL) begin
        ctrl_reg <= {wdata_reg[5:4], 1'b0, wdata_reg[2:1], 1'b0};
      end
      if (do_write && awaddr_reg == ADDR_WDATA) begin
        tx_word_reg <= wdata_reg[23:0];
      end
    end
  end

  // Read channel, unmapped addresses answer with an error
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= addr_ok(s_axi_araddr_in) ? rd_word : 32'h00000000;
      s_axi_rresp_out <= addr_ok(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine: divider-made clock, low half then high half per bit
  logic [23:0] wait_cnt_reg;
  logic [3:0] phase_reg;
  logic [4:0] bit_cnt_reg;
  logic [31:0] sh_reg;
  logic rd_op_reg;
  logic use_cs_reg;
  wire logic use_cs = ctrl_reg[CTRL_USE_CS];
  wire logic last_phase = (phase_reg == 4'(2 * SCLK_HALF_CYC - 1));
  wire logic [23:0] gap_cyc = use_cs_reg ? 24'(GAP_CS_CYC) : 24'(GAP_NOCS_CYC);
  // Bit 13 forced high on command writes for older parts
  wire logic [23:0] tx_fix = (ctrl_reg[5:4] == SEL_CMD) ? (tx_word_reg | CMD_FIXED_MASK) : tx_word_reg;
  wire logic [7:0] cmd_byte = {ctrl_reg[CTRL_READ], 5'h00, ctrl_reg[5:4]};
  logic sdio_s1_reg;
  logic sdio_s2_reg;

  // Read data comes from the far chip, so two flops before use
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sdio_s1_reg <= 1'b1;
      sdio_s2_reg <= 1'b1;
    end else begin
      sdio_s1_reg <= link.sdio;
      sdio_s2_reg <= sdio_s1_reg;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= H_BOOT;
      wait_cnt_reg <= 24'h000000;
      phase_reg <= 4'h0;
      bit_cnt_reg <= 5'h00;
      sh_reg <= 32'h00000000;
      rx_word_reg <= 24'h000000;
      rd_op_reg <= 1'b0;
      use_cs_reg <= 1'b0;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.host_sdio_o <= 1'b1;
      link.host_sdio_oe <= 1'b0;
    end else begin
      phase_reg <= (state_reg == H_CMD || state_reg == H_DATA) ? phase_reg + 4'h1 : 4'h0;
      link.sclk <= (state_reg == H_CMD || state_reg == H_DATA) && phase_reg >= 4'(SCLK_HALF_CYC - 1) &&
                   !last_phase;
      case (state_reg)
        H_BOOT: begin
          // Lets the oscillator start and any stale frame time out
          wait_cnt_reg <= wait_cnt_reg + 24'h000001;
          if (wait_cnt_reg == 24'(STARTUP_WAIT_CYC - 1)) begin
            state_reg <= H_IDLE;
          end
        end
        H_IDLE: begin
          link.cs_n <= use_cs;
          if (go_reg) begin
            state_reg <= H_CMD;
            sh_reg <= {cmd_byte, tx_fix};
            rd_op_reg <= ctrl_reg[CTRL_READ];
            use_cs_reg <= use_cs;
            bit_cnt_reg <= 5'h00;
            link.cs_n <= 1'b0;
            link.host_sdio_oe <= 1'b1;
            link.host_sdio_o <= cmd_byte[7];
          end
        end
        H_CMD, H_DATA: begin
          if (phase_reg == 4'(2 * SCLK_HALF_CYC - 2) && rd_op_reg && state_reg == H_DATA) begin
            rx_word_reg <= {rx_word_reg[22:0], sdio_s2_reg};
          end
          if (last_phase) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            sh_reg <= {sh_reg[30:0], 1'b0};
            link.host_sdio_o <= sh_reg[30];
            wait_cnt_reg <= 24'h000000;
            if (state_reg == H_CMD && bit_cnt_reg == 5'(CMD_BITS - 1)) begin
              state_reg <= H_GAP;
              bit_cnt_reg <= 5'h00;
              link.host_sdio_oe <= !rd_op_reg;
            end else if (state_reg == H_DATA && bit_cnt_reg == 5'(FRAME_BITS - CMD_BITS - 1)) begin
              state_reg <= H_END;
              link.host_sdio_oe <= 1'b0;
            end
          end
        end
        H_GAP: begin
          // Timed from the end of the byte, not its start
          wait_cnt_reg <= wait_cnt_reg + 24'h000001;
          if (wait_cnt_reg == gap_cyc - 24'h000001) begin
            state_reg <= H_DATA;
          end
        end
        H_END: begin
          wait_cnt_reg <= wait_cnt_reg + 24'h000001;
          if (wait_cnt_reg == gap_cyc - 24'h000001) begin
            // Select rises only after the device has let go of the wire
            link.cs_n <= use_cs_reg;
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: pkg/dac_link_pkg.sv */
package dac_link_pkg;
  // Clock and serial timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_CYC = 8;
  localparam int IO_TIMEOUT_NS = 20000;
  localparam int IO_TIMEOUT_CYC = IO_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int SCLK_RST_NS = 8000;
  localparam int SCLK_RST_CYC = SCLK_RST_NS / CLK_PERIOD_NS;
  localparam int GAP_CS_NS = 1000;
  localparam int GAP_CS_CYC = (GAP_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_NOCS_NS = 2000;
  localparam int GAP_NOCS_CYC = (GAP_NOCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_MS = 150;
  localparam int STARTUP_CYC = STARTUP_MS * (1000000 / CLK_PERIOD_NS);
  localparam int SELFCAL_CYC = 16;
  // Frame layout: command byte then 24 data bits
  localparam int CMD_BITS = 8;
  localparam int FRAME_BITS = 32;
  localparam int CMD_READ_BIT = 7;
  localparam logic [1:0] SEL_CMD = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_OFFSET = 2'h2;
  localparam logic [1:0] SEL_GAIN = 2'h3;
  // Device register contents
  localparam logic [23:0] GAIN_RST = 24'h800000;
  localparam logic [23:0] DATA_RST = 24'h000000;
  localparam logic [23:0] OFFSET_RST = 24'h000000;
  localparam int GAIN_FRAC = 23;
  localparam int CMD_FIXED_BIT = 13;
  localparam logic [23:0] CMD_FIXED_MASK = 24'h002000;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SELFCAL = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  // Host register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WDATA = 8'h04;
  localparam logic [7:0] ADDR_RDATA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_USE_CS = 2;
  localparam int CTRL_SEL_LO = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: pkg/dac_link_if.sv */
`timescale 1ns/1ps
interface dac_link_if;
  logic sclk;
  logic cs_n;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdio;
  // Resolved data wire, weak pull-up when nobody drives
  assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
  modport host (output sclk, output cs_n, output host_sdio_o, output host_sdio_oe, input sdio);
  modport device (input sclk, input cs_n, input sdio, output dev_sdio_o, output dev_sdio_oe);
endinterface

/* File: logic/gain_offset_scaler.sv */
`timescale 1ns/1ps
module gain_offset_scaler (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [23:0] code_in,
  input wire logic [23:0] gain_in,
  input wire logic [23:0] offset_in,
  output logic [23:0] scaled_out
);
  import dac_link_pkg::*;

  // Clip a signed sum into the unsigned code range
  function automatic logic [23:0] clip24(input logic signed [26:0] v);
    if (v < 0) begin
      clip24 = 24'h000000;
    end else if (v > 27'sh0ffffff) begin
      clip24 = 24'hffffff;
    end else begin
      clip24 = v[23:0];
    end
  endfunction

  // Gain is unsigned with unity at the top bit; offset is two's complement
  wire logic [47:0] product = code_in * gain_in;
  wire logic [24:0] scaled = product[47:GAIN_FRAC];
  wire logic signed [26:0] summed = $signed({2'h0, scaled}) + $signed({{3{offset_in[23]}}, offset_in});

  // Registered so the converter sees a steady code
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      scaled_out <= DATA_RST;
    end else begin
      scaled_out <= clip24(summed);
    end
  end
endmodule

/* File: logic/dac_dev_end.sv */
// Functional notes
// - Output code multiplied by gain constant
// - Sleep writes stored, output left unchanged
// - Entering Normal applies stored values at once
// - Gain register resets to 800000h
// - Command bit 13 reads one, ignores writes
// - Host always writes one to bit 13
// - Clock reset pattern counted on own oscillator
// - Host waits for oscillator before pattern (host waits at boot but never sends the clock reset pattern)
// - Recovery timeout abandons partial transactions
// - Write-only host waits 150 ms first
// - Observe interface delays, with or without select
// - Host delays start after byte completes
// - Data pin turns around for reads
// - Two-wire host grounds select, one direction (host still allows reads with use_cs clear)
// - Mode field: normal, self-cal, sleep, reserved
// - Offset added to code before conversion
// - Normal mode code sets the output
`timescale 1ns/1ps
module dac_dev_end (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  dac_link_if.device link,
  output logic [23:0] dac_code_out,
  output logic [1:0] op_mode_out
);
  import dac_link_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, the oscillator clock samples every link pin
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_d_reg;
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic sdio_s1_reg;
  logic sdio_s2_reg;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      sdio_s1_reg <= 1'b1;
      sdio_s2_reg <= 1'b1;
    end else begin
      sclk_s1_reg <= link.sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg <= sclk_s2_reg;
      cs_s1_reg <= link.cs_n;
      cs_s2_reg <= cs_s1_reg;
      sdio_s1_reg <= link.sdio;
      sdio_s2_reg <= sdio_s1_reg;
    end
  end

  // Edges found from the second stage only
  wire logic sclk_rise = sclk_s2_reg && !sclk_d_reg;
  wire logic sclk_fall = !sclk_s2_reg && sclk_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdogs: recovery timeout and clock reset pattern
  logic [11:0] idle_cnt_reg;
  logic [11:0] idle_cnt_next;
  logic [11:0] high_cnt_reg;
  logic [11:0] high_cnt_next;
  logic [5:0] bit_cnt_reg;

  wire logic in_frame = (bit_cnt_reg != 6'h00);
  wire logic timeout_hit = (idle_cnt_reg == 12'(IO_TIMEOUT_CYC));
  wire logic pattern_hit = (high_cnt_reg == 12'(SCLK_RST_CYC));
  // Select is optional: tied low it never aborts, so the timers must
  wire logic abandon = cs_s2_reg || timeout_hit || pattern_hit;

  // Idle counter runs only inside a frame; clock-high counter saturates
  assign idle_cnt_next = (!in_frame || sclk_rise || sclk_fall) ? 12'h000 :
                         (timeout_hit ? idle_cnt_reg : idle_cnt_reg + 12'h001);
  assign high_cnt_next = !sclk_s2_reg ? 12'h000 : (pattern_hit ? high_cnt_reg : high_cnt_reg + 12'h001);

  // Counted on own clock, so no detection while it is stopped
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      idle_cnt_reg <= 12'h000;
      high_cnt_reg <= 12'h000;
    end else begin
      idle_cnt_reg <= idle_cnt_next;
      high_cnt_reg <= high_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter
  logic [31:0] rx_sh_reg;
  logic [7:0] cmd_reg;
  logic [23:0] tx_sh_reg;
  logic drive_reg;
  logic [1:0] mode_reg;
  logic [23:0] data_reg;
  logic [23:0] offset_reg;
  logic [23:0] gain_reg;

  wire logic [7:0] cmd_now = {rx_sh_reg[6:0], sdio_s2_reg};
  wire logic cmd_done = sclk_rise && (bit_cnt_reg == 6'(CMD_BITS - 1));
  wire logic frame_end = sclk_fall && (bit_cnt_reg == 6'(FRAME_BITS));
  wire logic is_read = cmd_reg[CMD_READ_BIT];
  wire logic wr_commit = frame_end && !is_read;
  wire logic [1:0] wr_sel = cmd_reg[1:0];
  wire logic [23:0] wr_val = rx_sh_reg[23:0];

  // Readback word; the fixed bit is always one on this revision
  wire logic [23:0] cmd_view = CMD_FIXED_MASK | {22'h000000, mode_reg};
  wire logic [23:0] rd_val = (cmd_now[1:0] == SEL_CMD) ? cmd_view :
                             (cmd_now[1:0] == SEL_DATA) ? data_reg :
                             (cmd_now[1:0] == SEL_OFFSET) ? offset_reg : gain_reg;

  // Device takes bits on rising edges and shifts out on falling edges
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || abandon) begin
      bit_cnt_reg <= 6'h00;
      rx_sh_reg <= 32'h00000000;
      cmd_reg <= 8'h00;
      tx_sh_reg <= 24'h000000;
      drive_reg <= 1'b0;
    end else if (sclk_rise && bit_cnt_reg != 6'(FRAME_BITS)) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
      rx_sh_reg <= {rx_sh_reg[30:0], sdio_s2_reg};
      if (cmd_done) begin
        cmd_reg <= cmd_now;
        tx_sh_reg <= rd_val;
      end
    end else if (frame_end) begin
      bit_cnt_reg <= 6'h00;
      drive_reg <= 1'b0;
    end else if (sclk_fall && is_read && bit_cnt_reg >= 6'(CMD_BITS)) begin
      // Turn around after the host released the pin on this edge
      drive_reg <= 1'b1;
      if (drive_reg) begin
        tx_sh_reg <= {tx_sh_reg[22:0], 1'b0};
      end
    end
  end

  assign link.dev_sdio_o = tx_sh_reg[23];
  assign link.dev_sdio_oe = drive_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and mode control
  logic [4:0] cal_cnt_reg;
  wire logic wr_mode_ok = wr_commit && wr_sel == SEL_CMD && wr_val[1:0] != 2'h3;
  wire logic cal_done = (mode_reg == MODE_SELFCAL) && (cal_cnt_reg == 5'(SELFCAL_CYC - 1));

  // Reserved mode code ignored; self-cal returns to Normal by itself
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mode_reg <= MODE_NORMAL;
      cal_cnt_reg <= 5'h00;
    end else begin
      cal_cnt_reg <= (mode_reg == MODE_SELFCAL) ? cal_cnt_reg + 5'h01 : 5'h00;
      if (wr_mode_ok) begin
        mode_reg <= wr_val[1:0];
      end else if (cal_done) begin
        mode_reg <= MODE_NORMAL;
      end
    end
  end

  // Writes store whatever the mode, unless self-cal ends in the same cycle; bit 13 is not kept
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      data_reg <= DATA_RST;
      offset_reg <= OFFSET_RST;
      gain_reg <= GAIN_RST;
    end else if (cal_done) begin
      offset_reg <= OFFSET_RST;
      gain_reg <= GAIN_RST;
    end else if (wr_commit) begin
      if (wr_sel == SEL_DATA) begin
        data_reg <= wr_val;
      end
      if (wr_sel == SEL_OFFSET) begin
        offset_reg <= wr_val;
      end
      if (wr_sel == SEL_GAIN) begin
        gain_reg <= wr_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Values in effect: follow the stored ones only in Normal mode
  logic [23:0] act_data_reg;
  logic [23:0] act_offset_reg;
  logic [23:0] act_gain_reg;
  wire logic in_normal = (mode_reg == MODE_NORMAL);

  // Held in Sleep, picked up the first cycle back in Normal
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      act_data_reg <= DATA_RST;
      act_offset_reg <= OFFSET_RST;
      act_gain_reg <= GAIN_RST;
    end else if (in_normal) begin
      act_data_reg <= data_reg;
      act_offset_reg <= offset_reg;
      act_gain_reg <= gain_reg;
    end
  end

  // Gain then offset applied on the way to the converter
  gain_offset_scaler scaler_u (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .code_in(act_data_reg),
    .gain_in(act_gain_reg),
    .offset_in(act_offset_reg),
    .scaled_out(dac_code_out)
  );

  // Mode seen from outside
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      op_mode_out <= MODE_NORMAL;
    end else begin
      op_mode_out <= mode_reg;
    end
  end
endmodule

/* File: dv/dac_link_monitor.sv */
`timescale 1ns/1ps
module dac_link_monitor
  import dac_link_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_oe,
  input wire logic [23:0] dac_code_out,
  input wire logic [1:0] op_mode_out
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  // Wire ownership: overlap here would mean a bus fight
  a_one_driver: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data wire");
  a_dev_in_frame: assert property (dev_sdio_oe |-> !cs_n)
    else $error("device drives outside a frame");
  // Link clock shape, eight cycles per half bit
  a_sclk_low_time: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("link clock low phase too short");
  a_sclk_high_time: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high phase wrong");
  a_clock_in_frame: assert property (sclk |-> !cs_n)
    else $error("link clock runs while deselected");
  ////////////////////////////////////////////////////////////
  // Mode field and output behaviour
  a_mode_legal: assert property (op_mode_out != 2'h3)
    else $error("reserved mode entered");
  a_sleep_holds: assert property ((op_mode_out == MODE_SLEEP) && $past(op_mode_out == MODE_SLEEP)
    |-> $stable(dac_code_out)) else $error("output moved in sleep");
  // Exactly sixteen cycles of self-cal, a shorter one would slip past a range
  a_selfcal_len: assert property ($rose(op_mode_out == MODE_SELFCAL) |->
    (op_mode_out == MODE_SELFCAL) [*8] ##1 (op_mode_out == MODE_SELFCAL) [*8] ##1 (op_mode_out == MODE_NORMAL))
    else $error("self-cal length wrong");
  c_readback: cover property ($rose(dev_sdio_oe));
  c_sleep: cover property ($rose(op_mode_out == MODE_SLEEP));
  c_selfcal: cover property ($rose(op_mode_out == MODE_SELFCAL));
endmodule

/* File: dv/dac_gain_cal_and_serial_host_rules_tb_top.sv */
`timescale 1ns/1ps
module dac_gain_cal_and_serial_host_rules_tb_top;
  import dac_link_pkg::*;
  logic clk;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, op_mode, rsp;
  logic [31:0] rdata, v, code_w, mode_w;
  logic [23:0] dac_code;
  int fails = 0;
  int comparisons = 0;
  // Widened views for the shared compare
  assign code_w = {8'h00, dac_code};
  assign mode_w = {30'h0, op_mode};
  ////////////////////////////////////////////////////////////
  dac_link_if dac_link_if_i ();
  dac_dev_end dac_dev_end_i (.ref_clk_in(clk), .rst_n_in(rst_n), .link(dac_link_if_i),
    .dac_code_out(dac_code), .op_mode_out(op_mode));
  // Short boot so the run stays small
  dac_host_end #(.STARTUP_WAIT_CYC(200)) dac_host_end_i (.ref_clk_in(clk), .rst_n_in(rst_n),
    .link(dac_link_if_i), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  dac_link_monitor dac_link_monitor_i (.ref_clk_in(clk), .rst_n_in(rst_n), .sclk(dac_link_if_i.sclk),
    .cs_n(dac_link_if_i.cs_n), .host_sdio_oe(dac_link_if_i.host_sdio_oe),
    .dev_sdio_oe(dac_link_if_i.dev_sdio_oe), .dac_code_out(dac_code), .op_mode_out(op_mode));
  ////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // A used-up wait ends the run as a failure
  task automatic bound(input int n);
    if (n >= 2000) begin
      fails++;
      complete_run();
    end
  endtask
  // Handshakes hold until taken; each task starts one edge later to avoid double drives
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 2000);
    rsp = bresp;
    bready <= 1'b0;
    bound(n);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 2000);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
    bound(n);
  endtask
  task automatic poll(input int b, input logic val);
    int n;
    n = 0;
    do begin
      axi_rd(ADDR_STATUS, v);
      n++;
    end while (v[b] !== val && n < 2000);
    bound(n);
  endtask
  task automatic dwr(input logic [1:0] s, input logic [23:0] d, input logic cs);
    axi_wr(ADDR_WDATA, {8'h00, d});
    axi_wr(ADDR_CTRL, {26'h0, s, 1'b0, cs, 2'b01});
    poll(0, 1'b0);
  endtask
  task automatic drd(input logic [1:0] s, output logic [31:0] d);
    axi_wr(ADDR_CTRL, {26'h0, s, 4'b0111});
    poll(0, 1'b0);
    axi_rd(ADDR_RDATA, d);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence: expected codes are (data*gain)>>23 plus offset
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    poll(1, 1'b1);
    drd(SEL_GAIN, v);
    chk(v, 32'h00800000);
    dwr(SEL_CMD, 24'h000000, 1'b1);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    drd(SEL_CMD, v);
    chk(v, 32'h00002000);
    dwr(SEL_DATA, 24'h400000, 1'b1);
    chk(code_w, 32'h00400000);
    dwr(SEL_GAIN, 24'h400000, 1'b1);
    chk(code_w, 32'h00200000);
    dwr(SEL_OFFSET, 24'h000010, 1'b1);
    chk(code_w, 32'h00200010);
    dwr(SEL_CMD, 24'h002002, 1'b1);
    chk(mode_w, 32'h2);
    dwr(SEL_GAIN, 24'h800000, 1'b1);
    chk(code_w, 32'h00200010);
    drd(SEL_GAIN, v);
    chk(v, 32'h00800000);
    dwr(SEL_CMD, 24'h002000, 1'b1);
    chk(code_w, 32'h00400010);
    dwr(SEL_DATA, 24'h100000, 1'b0);
    chk(code_w, 32'h00100010);
    dwr(SEL_CMD, 24'h002003, 1'b1);
    chk(mode_w, 32'h0);
    dwr(SEL_CMD, 24'h002001, 1'b1);
    drd(SEL_OFFSET, v);
    chk(v, 32'h0);
    chk(code_w, 32'h00100000);
    axi_rd(8'h10, v);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Unmapped write must answer with an error response too
    axi_wr(8'h10, 32'h00000000);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    complete_run();
  end
endmodule
